// File: core/fftic_top.sv
// FIFO fill, transmit launch and interrupt control with an APB slave
//
// Overview of operation
// RULE1: Auto mode: sync word starts buffered filling
// RULE2: Manual mode: host fill bit starts/stops storing
// RULE3: Auto fill bit stays set until cleared
// RULE4: Clearing fill bit waits for next sync
// RULE5: Transmit finished flag rises after last bit
// RULE6: Buffered: launch on non-empty, route to A
// RULE7: Packet, select 0: launch at level reached
// RULE8: Packet, select 0: level reached drives A
// RULE9: Packet, select 1: non-empty launches, drives A
// RULE10: Signal interrupt enable resets off, host sets
// RULE11: Signal flag sets above threshold, one clears
// RULE12: Threshold compares in signal reading encoding
// RULE13: Mode 00 continuous, 01 buffered, 1x packet
// RULE14: Overrun flag; one-write clears flag and queue
// RULE15: Event set beats simultaneous host clear
//
// The APB register port is this design's own decision.
module fftic_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sync_detect,
    input wire logic tx_last_bit,
    input wire logic fifo_overrun,
    input wire logic [6:0] fifo_count,
    input wire logic [7:0] signal_level,
    output logic fill_en,
    output logic fifo_flush,
    output logic tx_start,
    output logic irq_a,
    output logic irq
);
    typedef struct packed {
        logic method;
        logic fill;
        logic txdone;
        logic launch;
        logic sig_en;
        logic [1:0] mode;
        logic [5:0] level;
        logic [7:0] thr;
        logic [3:0] mask;
        logic above;
        logic tx_start_d;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
        logic fill_en;
        logic flush;
    } fftic_top_st_t;

    localparam fftic_top_st_t ST_RST = '{
        method: fftic_pkg::RST_METHOD,
        launch: fftic_pkg::RST_LAUNCH,
        sig_en: fftic_pkg::RST_SIGEN,
        mode: fftic_pkg::RST_MODE,
        level: fftic_pkg::RST_LEVEL,
        thr: fftic_pkg::RST_THR,
        mask: fftic_pkg::RST_MASK,
        default: '0
    };

    fftic_top_st_t s_r;
    fftic_top_st_t s_nxt;

    logic [5:0] idx;
    logic aligned;
    logic hit;
    logic acc_end;
    logic wr;
    logic wr_fti;
    logic wr_cfg;
    logic wr_thr;
    logic wr_istat;
    logic wr_imask;
    logic wr_stat;
    fftic_pkg::fftic_mode_t mode_dec;
    logic is_buf;
    logic above_now;
    logic sig_rise;
    logic auto_sync;
    logic ovr_clr;
    logic tx_rise;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic [3:0] istat;
    logic [1:0] fl_set;
    logic [1:0] fl_clr;
    logic [1:0] fl;
    logic [31:0] rd;

    // Address decode; unaligned or unmapped access answers with an error
    assign idx = paddr[fftic_pkg::IDX_LSB +: fftic_pkg::IDX_W];
    assign aligned = (paddr[fftic_pkg::IDX_LSB-1:0] == '0);
    assign hit = aligned & fftic_pkg::reg_known(idx);

    // A write lands only on the edge that completes the access phase
    assign acc_end = psel & penable & s_r.pready;
    assign wr = acc_end & pwrite & hit;
    assign wr_fti = wr & (idx == fftic_pkg::IDX_FTI);
    assign wr_cfg = wr & (idx == fftic_pkg::IDX_CFG);
    assign wr_thr = wr & (idx == fftic_pkg::IDX_THR);
    assign wr_istat = wr & (idx == fftic_pkg::IDX_ISTAT);
    assign wr_imask = wr & (idx == fftic_pkg::IDX_IMASK);
    assign wr_stat = wr & (idx == fftic_pkg::IDX_STAT);

    // Data handling mode decode
    assign mode_dec = fftic_pkg::decode_mode(s_r.mode); // RULE13
    assign is_buf = (mode_dec == fftic_pkg::FFTIC_MODE_BUF);

    // Same code on both sides, so a plain magnitude compare suffices
    assign above_now = (signal_level > s_r.thr); // RULE12
    // Edge rather than level: one event per crossing, not per cycle
    assign sig_rise = s_r.sig_en & above_now & ~s_r.above; // RULE11

    // Sync word start of automatic filling, buffered mode only
    assign auto_sync = is_buf & ~s_r.method & sync_detect; // RULE1
    assign ovr_clr = wr_stat & pwdata[fftic_pkg::STAT_OVR]; // RULE14
    assign tx_rise = tx_start & ~s_r.tx_start_d;

    // Events feeding the interrupt status bank
    always_comb begin
        ev_set = '0;
        ev_set[fftic_pkg::EV_FILL] = auto_sync & ~s_r.fill;
        ev_set[fftic_pkg::EV_TXDONE] = tx_last_bit;
        ev_set[fftic_pkg::EV_SIG] = sig_rise;
        ev_set[fftic_pkg::EV_OVR] = fifo_overrun;
        ev_clr = wr_istat ? pwdata[fftic_pkg::IRQ_LSB +: fftic_pkg::EV_N] :
            '0;
    end

    fftic_sticky #(
        .N(fftic_pkg::EV_N)
    ) u_irq_status (
        .pclk(pclk),
        .presetn(presetn),
        .set(ev_set),
        .clr(ev_clr),
        .flags(istat)
    );

    // Signal-level flag and queue overrun flag, both one-to-clear
    always_comb begin
        fl_set = '0;
        fl_clr = '0;
        fl_set[fftic_pkg::FL_SIG] = sig_rise; // RULE11
        fl_clr[fftic_pkg::FL_SIG] = wr_fti & pwdata[fftic_pkg::B_SIGFLAG];
        fl_set[fftic_pkg::FL_OVR] = fifo_overrun; // RULE14
        fl_clr[fftic_pkg::FL_OVR] = ovr_clr; // RULE14
    end

    fftic_sticky #(
        .N(fftic_pkg::FL_N)
    ) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set(fl_set),
        .clr(fl_clr),
        .flags(fl)
    );

    fftic_launch u_launch (
        .pclk(pclk),
        .presetn(presetn),
        .mode(mode_dec),
        .launch_sel(s_r.launch),
        .fifo_count(fifo_count),
        .level(s_r.level),
        .tx_start(tx_start),
        .irq_a(irq_a)
    );

    // Read mux; reserved and unused bits read as zero
    always_comb begin
        rd = '0;
        case (idx)
            fftic_pkg::IDX_FTI: begin
                rd[fftic_pkg::B_METHOD] = s_r.method;
                rd[fftic_pkg::B_FILL] = s_r.fill;
                rd[fftic_pkg::B_TXDONE] = s_r.txdone;
                rd[fftic_pkg::B_LAUNCH] = s_r.launch;
                rd[fftic_pkg::B_SIGEN] = s_r.sig_en;
                rd[fftic_pkg::B_SIGFLAG] = fl[fftic_pkg::FL_SIG];
            end
            fftic_pkg::IDX_CFG: begin
                rd[fftic_pkg::CFG_MODE_LSB +: fftic_pkg::MODE_W] = s_r.mode;
                rd[fftic_pkg::CFG_LEVEL_LSB +: fftic_pkg::LEVEL_W] =
                    s_r.level;
            end
            fftic_pkg::IDX_THR: begin
                rd[fftic_pkg::THR_LSB +: fftic_pkg::THR_W] = s_r.thr;
            end
            fftic_pkg::IDX_ISTAT: begin
                rd[fftic_pkg::IRQ_LSB +: fftic_pkg::EV_N] = istat;
            end
            fftic_pkg::IDX_IMASK: begin
                rd[fftic_pkg::IRQ_LSB +: fftic_pkg::EV_N] = s_r.mask;
            end
            fftic_pkg::IDX_STAT: begin
                rd[fftic_pkg::STAT_OVR] = fl[fftic_pkg::FL_OVR];
                rd[fftic_pkg::STAT_CNT_LSB +: fftic_pkg::CNT_W] = fifo_count;
            end
            default: begin
                rd = '0;
            end
        endcase
    end

    // Next-state logic for control bits, bus answer and outputs
    always_comb begin
        s_nxt = s_r;
        // One wait state: ready rises in the second access cycle
        s_nxt.pready = psel & penable & ~s_r.pready;
        if (psel & penable & ~s_r.pready) begin
            s_nxt.prdata = (pwrite | ~hit) ? '0 : rd;
            s_nxt.pslverr = ~hit;
        end
        if (wr_fti) begin
            s_nxt.method = pwdata[fftic_pkg::B_METHOD];
            s_nxt.launch = pwdata[fftic_pkg::B_LAUNCH];
            s_nxt.sig_en = pwdata[fftic_pkg::B_SIGEN]; // RULE10
        end
        if (wr_cfg) begin
            s_nxt.mode = pwdata[fftic_pkg::CFG_MODE_LSB +: fftic_pkg::MODE_W];
            s_nxt.level =
                pwdata[fftic_pkg::CFG_LEVEL_LSB +: fftic_pkg::LEVEL_W];
        end
        if (wr_thr) begin
            s_nxt.thr = pwdata[fftic_pkg::THR_LSB +: fftic_pkg::THR_W];
        end
        if (wr_imask) begin
            s_nxt.mask = pwdata[fftic_pkg::IRQ_LSB +: fftic_pkg::EV_N];
        end
        // Fill bit: host-driven in manual mode, sync-set in auto mode.
        // A write that also switches the method obeys the new method, so
        // one write can select manual filling and start it together.
        if (wr_fti ? pwdata[fftic_pkg::B_METHOD] : s_r.method) begin
            if (wr_fti) begin
                s_nxt.fill = pwdata[fftic_pkg::B_FILL]; // RULE2
            end
        end else begin
            s_nxt.fill = auto_sync | (s_r.fill // RULE3
                & ~(wr_fti & pwdata[fftic_pkg::B_FILL])); // RULE4
        end
        // Storing stops while an overrun waits to be cleared
        s_nxt.fill_en = is_buf & s_nxt.fill & ~fl[fftic_pkg::FL_OVR];
        // Done flag held until the next transmission starts
        s_nxt.txdone = tx_last_bit | (s_r.txdone & ~tx_rise); // RULE5
        s_nxt.tx_start_d = tx_start;
        s_nxt.above = above_now;
        s_nxt.flush = ovr_clr; // RULE14
        s_nxt.irq = |(istat & s_r.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign fill_en = s_r.fill_en;
    assign fifo_flush = s_r.flush;
    assign irq = s_r.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence acc_first_s;
        psel && penable && !pready;
    endsequence
    sequence ready_pulse_s;
        pready ##1 !pready;
    endsequence
    apb_one_wait_a: assert property (acc_first_s |=> ready_pulse_s)
        else $error("APB ready not a one-cycle answer");

    irq_level_a: assert property (##1 irq == $past(|(istat & s_r.mask)))
        else $error("interrupt output does not follow masked status");

    sequence auto_sync_s;
        is_buf && !s_r.method && sync_detect
        && !(wr_fti && pwdata[fftic_pkg::B_METHOD]);
    endsequence
    fill_auto_a: assert property (auto_sync_s |=> s_r.fill // RULE1
        ##1 (fill_en || fl[fftic_pkg::FL_OVR] || !is_buf || $past(wr_fti)
        || $past(fl[fftic_pkg::FL_OVR])))
        else $error("auto fill did not start on sync word");

    manual_fill_a: assert property ((wr_fti // RULE2
        && pwdata[fftic_pkg::B_METHOD]) |=>
        s_r.fill == $past(pwdata[fftic_pkg::B_FILL]))
        else $error("manual fill bit not taken from write");

    fill_hold_a: assert property ((!s_r.method && s_r.fill // RULE3
        && !wr_fti && $stable(s_r.method)) |=> s_r.fill)
        else $error("auto fill bit dropped without a clear");

    txdone_set_a: assert property (tx_last_bit |=> s_r.txdone) // RULE5
        else $error("transmit finished flag not raised");

    sig_flag_a: assert property (sig_rise |=> fl[fftic_pkg::FL_SIG]) // RULE11
        else $error("signal-level flag not set on crossing");

    flush_pulse_a: assert property (ovr_clr |=> fifo_flush // RULE14
        && !fl[fftic_pkg::FL_OVR] || $past(fifo_overrun))
        else $error("overrun clear did not flush queue");
endmodule // fftic_top

// File: shared/fftic_pkg.sv
// Constants, types and decode helpers for the FIFO fill / transmit launch block
package fftic_pkg;
    // Bus geometry: each register index maps to byte address index*4
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_W = 6;
    // Register indices
    localparam logic [5:0] IDX_FTI = 6'h0e;
    localparam logic [5:0] IDX_CFG = 6'h10;
    localparam logic [5:0] IDX_THR = 6'h11;
    localparam logic [5:0] IDX_ISTAT = 6'h12;
    localparam logic [5:0] IDX_IMASK = 6'h13;
    localparam logic [5:0] IDX_STAT = 6'h14;
    // Field positions in fifo_tx_irq_control
    localparam int unsigned B_METHOD = 7;
    localparam int unsigned B_FILL = 6;
    localparam int unsigned B_TXDONE = 5;
    localparam int unsigned B_LAUNCH = 4;
    localparam int unsigned B_SIGEN = 3;
    localparam int unsigned B_SIGFLAG = 2;
    // Configuration, threshold and status fields
    localparam int unsigned MODE_W = 2;
    localparam int unsigned MODE_PKT_BIT = 1;
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned LEVEL_W = 6;
    localparam int unsigned CFG_LEVEL_LSB = 8;
    localparam int unsigned CNT_W = 7;
    localparam int unsigned THR_W = 8;
    localparam int unsigned THR_LSB = 0;
    localparam int unsigned STAT_OVR = 0;
    localparam int unsigned STAT_CNT_LSB = 8;
    // Interrupt status and mask layout
    localparam int unsigned IRQ_LSB = 0;
    localparam int unsigned EV_N = 4;
    localparam int unsigned EV_FILL = 0;
    localparam int unsigned EV_TXDONE = 1;
    localparam int unsigned EV_SIG = 2;
    localparam int unsigned EV_OVR = 3;
    // Sticky flags kept for the control and status registers
    localparam int unsigned FL_N = 2;
    localparam int unsigned FL_SIG = 0;
    localparam int unsigned FL_OVR = 1;
    // Reset values
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [5:0] RST_LEVEL = 6'h0f;
    localparam logic [7:0] RST_THR = 8'h00;
    localparam logic RST_METHOD = 1'h0;
    localparam logic RST_LAUNCH = 1'h0;
    localparam logic RST_SIGEN = 1'h0;
    localparam logic [3:0] RST_MASK = 4'h0;

    typedef enum logic [1:0] {
        FFTIC_MODE_CONT,
        FFTIC_MODE_BUF,
        FFTIC_MODE_PKT
    } fftic_mode_t;

    // Upper bit set means packet mode whatever the lower bit
    function automatic fftic_mode_t decode_mode(input logic [1:0] m);
        if (m[MODE_PKT_BIT]) begin
            return FFTIC_MODE_PKT;
        end else if (m[0]) begin
            return FFTIC_MODE_BUF;
        end
        return FFTIC_MODE_CONT;
    endfunction

    // True for every index that holds a register
    function automatic logic reg_known(input logic [5:0] idx);
        case (idx)
            IDX_FTI, IDX_CFG, IDX_THR, IDX_ISTAT, IDX_IMASK,
            IDX_STAT: return 1'h1;
            default: return 1'h0;
        endcase
    endfunction
endpackage

// File: core/fftic_sticky.sv
// Bank of sticky flags: set by events, cleared by host one-writes
module fftic_sticky #(
    parameter int unsigned N = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    output logic [N-1:0] flags
);
    typedef struct packed {
        logic [N-1:0] flags;
    } fftic_sticky_st_t;

    fftic_sticky_st_t s_r;
    fftic_sticky_st_t s_nxt;
    logic [N-1:0] bit_nxt;

    // Set beats clear so an event in the clearing cycle survives
    for (genvar i = 0; i < N; i++) begin : g_flag
        assign bit_nxt[i] = set[i] | (s_r.flags[i] & ~clr[i]); // RULE15
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.flags = bit_nxt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign flags = s_r.flags;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    set_wins_clr_a: assert property ((|(set & clr)) |=> // RULE15
        ((flags & $past(set & clr)) == $past(set & clr)))
        else $error("sticky flag lost a set during clear");
    clr_drops_a: assert property ((|(clr & ~set)) |=>
        ((flags & $past(clr & ~set)) == '0))
        else $error("sticky flag did not clear");
endmodule // fftic_sticky

// File: core/fftic_launch.sv
// Transmit start condition and interrupt line A source selection
module fftic_launch (
    input wire logic pclk,
    input wire logic presetn,
    input wire fftic_pkg::fftic_mode_t mode,
    input wire logic launch_sel,
    input wire logic [6:0] fifo_count,
    input wire logic [5:0] level,
    output logic tx_start,
    output logic irq_a
);
    typedef struct packed {
        logic tx_start;
        logic irq_a;
    } fftic_launch_st_t;

    fftic_launch_st_t s_r;
    fftic_launch_st_t s_nxt;
    logic not_empty;
    logic level_hit;

    assign not_empty = (fifo_count != '0);
    assign level_hit = (fifo_count >= {1'h0, level});

    // Continuous mode has no queue, so nothing launches from here
    always_comb begin
        s_nxt = s_r;
        case (mode)
            fftic_pkg::FFTIC_MODE_BUF: begin
                s_nxt.tx_start = not_empty; // RULE6
                s_nxt.irq_a = not_empty; // RULE6
            end
            fftic_pkg::FFTIC_MODE_PKT: begin
                if (launch_sel) begin
                    s_nxt.tx_start = not_empty; // RULE9
                    s_nxt.irq_a = not_empty; // RULE9
                end else begin
                    s_nxt.tx_start = level_hit; // RULE7
                    s_nxt.irq_a = level_hit; // RULE8
                end
            end
            default: begin
                s_nxt.tx_start = 1'h0;
                s_nxt.irq_a = 1'h0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tx_start = s_r.tx_start;
    assign irq_a = s_r.irq_a;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    buf_launch_a: assert property ((mode == fftic_pkg::FFTIC_MODE_BUF) // RULE6
        |=> (tx_start == $past(not_empty)) && irq_a == tx_start)
        else $error("buffered launch not on non-empty queue");
    pkt_level_a: assert property ((mode == fftic_pkg::FFTIC_MODE_PKT // RULE7
        && !launch_sel) |=> tx_start == $past(level_hit)
        && irq_a == $past(level_hit))
        else $error("packet launch not on level reached");
    pkt_nonempty_a: assert property ((mode == fftic_pkg::FFTIC_MODE_PKT // RULE9
        && launch_sel) |=> irq_a == $past(not_empty))
        else $error("packet launch line A not on non-empty");
endmodule // fftic_launch

// File: test/fftic_queue_model.sv
// Queue partner model: holds a byte count, emptied on a flush pulse
module fftic_queue_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic push,
    input wire logic fifo_flush,
    output logic [6:0] fifo_count
);
    timeunit 1ns;
    timeprecision 1ns;
    // Count rises per pushed byte; flush wins so no stale byte survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_count <= 7'h00;
        end else if (fifo_flush) begin
            fifo_count <= 7'h00;
        end else if (push) begin
            fifo_count <= fifo_count + 7'h01;
        end
    end
endmodule // fftic_queue_model

// File: test/fftic_top_tb.sv
// Self-checking bench for the fill, launch and interrupt block
module fftic_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, fill_en, fifo_flush, tx_start, irq_a, irq;
    logic sync_detect = 1'h0;
    logic tx_last_bit = 1'h0;
    logic fifo_overrun = 1'h0;
    logic push = 1'h0;
    logic [6:0] fifo_count;
    logic [7:0] signal_level = 8'h00;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int comparisons = 0;

    // Free-running 10 MHz clock
    always #50 pclk = ~pclk;

    fftic_top fftic_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sync_detect(sync_detect),
        .tx_last_bit(tx_last_bit), .fifo_overrun(fifo_overrun),
        .fifo_count(fifo_count), .signal_level(signal_level),
        .fill_en(fill_en), .fifo_flush(fifo_flush), .tx_start(tx_start),
        .irq_a(irq_a), .irq(irq)
    );
    fftic_queue_model fftic_queue_model_inst (
        .pclk(pclk), .presetn(presetn), .push(push),
        .fifo_flush(fifo_flush), .fifo_count(fifo_count)
    );

    // Verdict and end of run, also reached by an expired wait
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One APB transfer; starting on a fresh edge keeps psel from being
    // assigned twice in one time step between back-to-back calls
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (n > 20) begin
                fail_count++;
                tally_and_finish();
            end
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        cmp(rd, exp);
    endtask

    task automatic push_one();
        @(posedge pclk);
        push <= 1'h1;
        @(posedge pclk);
        push <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask

    // Launch and interrupt pins answer one edge after the write that moves them
    task automatic settle();
        @(posedge pclk);
        @(negedge pclk);
    endtask

    // Main sequence; pin levels are looked at mid-cycle once settled
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rdc(8'h38, 32'h0);
        rdc(8'h40, 32'h0f00);
        rdc(8'h44, 32'h0);
        rdc(8'h4c, 32'h0);
        @(negedge pclk);
        cmp(32'({tx_start, irq_a, fill_en, irq}), 32'h0);
        // Unmapped and unaligned places are refused
        apb(1'h0, 8'h3c, 32'h0);
        cmp(32'(er), 32'h1);
        apb(1'h1, 8'h39, 32'hff);
        cmp(32'(er), 32'h1);
        rdc(8'h38, 32'h0);
        // Buffered mode, automatic fill on a sync word
        wr(8'h40, 32'h1);
        @(posedge pclk);
        sync_detect <= 1'h1;
        @(posedge pclk);
        sync_detect <= 1'h0;
        rdc(8'h38, 32'h40);
        @(negedge pclk);
        cmp(32'(fill_en), 32'h1);
        rdc(8'h48, 32'h1);
        wr(8'h38, 32'h40);
        rdc(8'h38, 32'h0);
        @(negedge pclk);
        cmp(32'(fill_en), 32'h0);
        wr(8'h48, 32'hf);
        @(negedge pclk);
        cmp(32'({tx_start, irq_a}), 32'h0);
        push_one();
        @(negedge pclk);
        cmp(32'({tx_start, irq_a}), 32'h3);
        // Manual fill follows the host bit
        wr(8'h38, 32'hc0);
        @(negedge pclk);
        cmp(32'(fill_en), 32'h1);
        wr(8'h38, 32'h80);
        @(negedge pclk);
        cmp(32'(fill_en), 32'h0);
        // Packet mode: launch at level 3, one below and at the boundary
        wr(8'h40, 32'h0302);
        push_one();
        @(negedge pclk);
        cmp(32'({tx_start, irq_a}), 32'h0);
        push_one();
        @(negedge pclk);
        cmp(32'({tx_start, irq_a}), 32'h3);
        wr(8'h40, 32'h0a03);
        settle();
        cmp(32'({tx_start, irq_a}), 32'h0);
        wr(8'h38, 32'h10);
        settle();
        cmp(32'({tx_start, irq_a}), 32'h3);
        wr(8'h40, 32'h0a00);
        settle();
        cmp(32'({tx_start, irq_a}), 32'h0);
        wr(8'h38, 32'h0);
        // Transmit finished, then an event against a clear of it
        @(posedge pclk);
        tx_last_bit <= 1'h1;
        @(posedge pclk);
        tx_last_bit <= 1'h0;
        rdc(8'h38, 32'h20);
        wr(8'h48, 32'hf);
        tx_last_bit <= 1'h1;
        wr(8'h48, 32'h2);
        tx_last_bit <= 1'h0;
        rdc(8'h48, 32'h2);
        // Signal level: equal is not above, one more is
        wr(8'h44, 32'h40);
        wr(8'h38, 32'h08);
        signal_level <= 8'h40;
        rdc(8'h38, 32'h28);
        signal_level <= 8'h41;
        rdc(8'h38, 32'h2c);
        @(negedge pclk);
        cmp(32'(irq), 32'h0);
        wr(8'h4c, 32'h4);
        settle();
        cmp(32'(irq), 32'h1);
        wr(8'h38, 32'h0c);
        rdc(8'h38, 32'h28);
        wr(8'h48, 32'hf);
        settle();
        cmp(32'(irq), 32'h0);
        // Overrun flag, cleared together with the queue
        @(posedge pclk);
        fifo_overrun <= 1'h1;
        @(posedge pclk);
        fifo_overrun <= 1'h0;
        rdc(8'h50, 32'h0301);
        wr(8'h50, 32'h1);
        rdc(8'h50, 32'h0);
        tally_and_finish();
    end
endmodule // fftic_top_tb
